// [shared/ppm_pkg.sv]
// ppm_pkg: register map, field positions, reset values and selector codes of the port pin mux
// assumes a 32-bit AXI4-Lite register bus; printed offsets are word indices
package ppm_pkg;

    // ****************************************
    // register indices and byte addresses
    // ****************************************
    localparam logic [7:0] PPM_IDX_FUNC_B = 8'h11;    // pin_function_ctrl_b
    localparam logic [7:0] PPM_IDX_OVR_C = 8'h12;     // pin_override_ctrl_c
    localparam logic [7:0] PPM_IDX_TEST = 8'h35;      // test_control_register
    localparam logic [7:0] PPM_IDX_STATUS = 8'h40;    // pin status readback
    localparam logic [9:0] PPM_ADDR_FUNC_B = {PPM_IDX_FUNC_B, 2'b00};
    localparam logic [9:0] PPM_ADDR_OVR_C = {PPM_IDX_OVR_C, 2'b00};
    localparam logic [9:0] PPM_ADDR_TEST = {PPM_IDX_TEST, 2'b00};
    localparam logic [9:0] PPM_ADDR_STATUS = {PPM_IDX_STATUS, 2'b00};

    // ****************************************
    // field positions
    // ****************************************
    localparam int PPM_CLK_INV_BIT = 0;
    localparam int PPM_CLK_SEL_LO = 1;
    localparam int PPM_SDO_INV_BIT = 4;
    localparam int PPM_SDO_SEL_LO = 5;
    localparam int PPM_AUX_INV_BIT = 0;
    localparam int PPM_AUX_SEL_LO = 1;
    localparam int PPM_RES_LO = 3;
    localparam int PPM_SEP_RX_BIT = 6;
    localparam int PPM_SEPARATE_SERIAL_OUTPUT_BIT = 7;
    localparam int PPM_TEST_SEL_LO = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] PPM_RST_FUNC_B = 8'h06;
    localparam logic [7:0] PPM_RST_OVR_C = 8'h00;
    localparam logic [7:0] PPM_RST_TEST = 8'h00;
    localparam logic [7:0] PPM_OVR_C_WMASK = 8'hc7;   // reserved bits stored as zero

    // ****************************************
    // selector codes
    // ****************************************
    typedef enum logic [2:0] {
        PPM_CLK_HIZ = 3'h0,
        PPM_CLK_ZERO = 3'h1,
        PPM_CLK_RXCLK = 3'h2,
        PPM_CLK_GEN = 3'h3,
        PPM_CLK_PLLFB = 3'h4,
        PPM_CLK_POLL = 3'h5,
        PPM_CLK_TEST3 = 3'h6,
        PPM_CLK_TEST4 = 3'h7
    } ppm_clk_sel_t;

    typedef enum logic [2:0] {
        PPM_SDO_HIZ = 3'h0,
        PPM_SDO_ZERO = 3'h1,
        PPM_SDO_RES2 = 3'h2,
        PPM_SDO_RXRDY = 3'h3,
        PPM_SDO_REFRDY = 3'h4,
        PPM_SDO_LORDY = 3'h5,
        PPM_SDO_RXRDY2 = 3'h6,
        PPM_SDO_RES7 = 3'h7
    } ppm_sdo_sel_t;

    typedef enum logic [1:0] {
        PPM_AUX_HIZ = 2'h0,
        PPM_AUX_LOW = 2'h1,
        PPM_AUX_RXM = 2'h2,
        PPM_AUX_RXM2 = 2'h3
    } ppm_aux_sel_t;

    // ****************************************
    // carriers
    // ****************************************
    // internal signals offered to the pins
    typedef struct packed {
        logic rx_clk;
        logic rx_data;
        logic rx_active;
        logic rx_mode_n;
        logic gen_clk;
        logic pll_fb_clk;
        logic poll_clk;
        logic rx_ready;
        logic ref_clk_ready;
        logic local_osc_ready;
        logic spi_sdo;
        logic spi_sdo_oe;
        logic [7:0] test_grp3;
        logic [7:0] test_grp4;
    } ppm_sources_t;

    // one pin driven as output value plus enable
    typedef struct packed {
        logic o;
        logic oe;
    } ppm_pin_t;

    // every driven pin and serial line
    typedef struct packed {
        ppm_pin_t clock_pin;
        ppm_pin_t serial_out_pin;
        ppm_pin_t aux_pin;
        ppm_pin_t data_pin;
        logic rx_data_to_serial_line;
        logic rx_data_to_sdo;
        logic rx_clk_to_sclk;
    } ppm_pins_t;

endpackage

// [rtl/ppm_pin_drive.sv]
// ppm_pin_drive: final pin stage, polarity inversion and tri-state for one pin
// assumes drive and level come from logic on the same clock
`timescale 1ns/1ps
module ppm_pin_drive (
    // pin function
    input wire logic drive,
    input wire logic level,
    input wire logic invert,
    // pin result
    output ppm_pkg::ppm_pin_t pin
);
    // inversion applies only to a driven level
    always_comb begin
        pin.oe = drive;
        pin.o = drive ? (level ^ invert) : 1'b0;
    end
endmodule // ppm_pin_drive

// [rtl/ppm_top.sv]
// ppm_top: port pin function mux with AXI4-Lite register access
// assumes internal sources are synchronous to clk; pins sampled by a host outside
//
// Function
// - clock pin selector in bits 3:1
// - clock codes: hiz, zero, gen, pllfb, poll
// - code 010 gives rx clock when enabled
// - codes 110/111 route test group signal
// - test group three source table
// - test group four source table
// - serial out pin selector code table
// - separate serial output overrides serial pin
// - separate rx output drives rx data on data pin while rx active
// - rx clock on clock pin only 010
// - invert bits flip clock and aux pins, and serial out pin while separate serial output is off
// - aux pin selector in bits 2:1
// - serial out selector 7:5, invert bit 4
// - aux codes: hiz, low, rx mode
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module ppm_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // internal sources
    input wire ppm_pkg::ppm_sources_t src,
    // pins and serial line steering
    output ppm_pkg::ppm_pins_t pins
);

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] func_b_r, func_b_nxt;
    logic [7:0] ovr_c_r, ovr_c_nxt;
    logic [7:0] test_r, test_nxt;

    // ****************************************
    // axi4-lite slave state
    // ****************************************
    logic aw_hold_r, aw_hold_nxt;
    logic w_hold_r, w_hold_nxt;
    logic [31:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic aw_take, w_take, ar_take, do_write;
    logic [31:0] wr_addr, wr_data;
    logic [3:0] wr_strb;

    // decoded address to register index, ok low when unmapped
    function automatic logic [1:0] reg_hit(input logic [31:0] addr, output logic ok);
        logic [9:0] a;
        a = addr[9:0];
        ok = (addr[31:10] == 22'h0);
        if (a == ppm_pkg::PPM_ADDR_FUNC_B) begin
            reg_hit = 2'h0;
        end else if (a == ppm_pkg::PPM_ADDR_OVR_C) begin
            reg_hit = 2'h1;
        end else if (a == ppm_pkg::PPM_ADDR_TEST) begin
            reg_hit = 2'h2;
        end else if (a == ppm_pkg::PPM_ADDR_STATUS) begin
            reg_hit = 2'h3;
        end else begin
            reg_hit = 2'h0;
            ok = 1'b0;
        end
    endfunction

    // ****************************************
    // bus handshakes
    // ****************************************
    // address and data accepted in either order, response after both
    always_comb begin
        aw_take = s_axi_awvalid && !aw_hold_r && !bvalid_r;
        w_take = s_axi_wvalid && !w_hold_r && !bvalid_r;
        ar_take = s_axi_arvalid && !rvalid_r;
        wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
        wr_data = w_hold_r ? wdata_r : s_axi_wdata;
        wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;
        do_write = (aw_hold_r || aw_take) && (w_hold_r || w_take);
    end

    // write channel next state
    always_comb begin
        logic ok;
        logic [1:0] idx;
        ok = 1'b0;
        idx = reg_hit(wr_addr, ok);
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        func_b_nxt = func_b_r;
        ovr_c_nxt = ovr_c_r;
        test_nxt = test_r;
        if (aw_take) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (w_take) begin
            w_hold_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = ok ? 2'b00 : 2'b10;
            if (ok && wr_strb[0]) begin
                unique case (idx)
                    2'h0: func_b_nxt = wr_data[7:0];
                    2'h1: func_b_nxt = func_b_r;
                    2'h2: test_nxt = wr_data[7:0];
                    2'h3: func_b_nxt = func_b_r;      // status is read only
                endcase
                if (idx == 2'h1) begin
                    // reserved bits kept zero
                    ovr_c_nxt = wr_data[7:0] & ppm_pkg::PPM_OVR_C_WMASK;
                end
            end
        end
    end

    // read channel next state
    always_comb begin
        logic ok;
        logic [1:0] idx;
        ok = 1'b0;
        idx = reg_hit(s_axi_araddr, ok);
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (ar_take) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = ok ? 2'b00 : 2'b10;
            rdata_nxt = 32'h0;
            if (ok) begin
                unique case (idx)
                    2'h0: rdata_nxt = {24'h0, func_b_r};
                    2'h1: rdata_nxt = {24'h0, ovr_c_r};
                    2'h2: rdata_nxt = {24'h0, test_r};
                    2'h3: rdata_nxt = {24'h0, pins.clock_pin.oe, pins.clock_pin.o,
                        pins.serial_out_pin.oe, pins.serial_out_pin.o,
                        pins.aux_pin.oe, pins.aux_pin.o,
                        pins.data_pin.oe, pins.data_pin.o};
                endcase
            end
        end
    end

    // bus and register flops
    always_ff @(posedge clk) begin
        if (rst) begin
            func_b_r <= ppm_pkg::PPM_RST_FUNC_B;
            ovr_c_r <= ppm_pkg::PPM_RST_OVR_C;
            test_r <= ppm_pkg::PPM_RST_TEST;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 32'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= 2'b00;
        end else begin
            func_b_r <= func_b_nxt;
            ovr_c_r <= ovr_c_nxt;
            test_r <= test_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // bus outputs straight from flops
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ****************************************
    // pin function decode
    // ****************************************
    ppm_pkg::ppm_clk_sel_t clk_sel;
    ppm_pkg::ppm_sdo_sel_t sdo_sel;
    ppm_pkg::ppm_aux_sel_t aux_sel;
    logic [2:0] test_sel;
    logic separate_serial_output, sep_rx, rx_on;
    logic clk_drv, clk_lvl, sdo_drv, sdo_lvl, aux_drv, aux_lvl;
    ppm_pkg::ppm_pin_t clk_pin_c, sdo_pin_c, aux_pin_c;
    ppm_pkg::ppm_pins_t pins_nxt;

    // field extraction
    always_comb begin
        clk_sel = ppm_pkg::ppm_clk_sel_t'(func_b_r[ppm_pkg::PPM_CLK_SEL_LO +: 3]);
        sdo_sel = ppm_pkg::ppm_sdo_sel_t'(func_b_r[ppm_pkg::PPM_SDO_SEL_LO +: 3]);
        aux_sel = ppm_pkg::ppm_aux_sel_t'(ovr_c_r[ppm_pkg::PPM_AUX_SEL_LO +: 2]);
        test_sel = test_r[ppm_pkg::PPM_TEST_SEL_LO +: 3];
        separate_serial_output = ovr_c_r[ppm_pkg::PPM_SEPARATE_SERIAL_OUTPUT_BIT];
        sep_rx = ovr_c_r[ppm_pkg::PPM_SEP_RX_BIT];
        rx_on = src.rx_active;
    end

    // clock pin source
    always_comb begin
        clk_drv = 1'b1;
        clk_lvl = 1'b0;
        unique case (clk_sel)
            ppm_pkg::PPM_CLK_HIZ: clk_drv = 1'b0;
            ppm_pkg::PPM_CLK_ZERO: clk_lvl = 1'b0;
            ppm_pkg::PPM_CLK_RXCLK: clk_lvl = sep_rx && rx_on && src.rx_clk;
            ppm_pkg::PPM_CLK_GEN: clk_lvl = src.gen_clk;
            ppm_pkg::PPM_CLK_PLLFB: clk_lvl = src.pll_fb_clk;
            ppm_pkg::PPM_CLK_POLL: clk_lvl = src.poll_clk;
            ppm_pkg::PPM_CLK_TEST3: clk_lvl = src.test_grp3[test_sel];
            ppm_pkg::PPM_CLK_TEST4: clk_lvl = src.test_grp4[test_sel];
        endcase
    end

    // serial out pin source, separate output wins
    always_comb begin
        sdo_drv = 1'b1;
        sdo_lvl = 1'b0;
        unique case (sdo_sel)
            ppm_pkg::PPM_SDO_HIZ: sdo_drv = 1'b0;
            ppm_pkg::PPM_SDO_ZERO: sdo_lvl = 1'b0;
            ppm_pkg::PPM_SDO_RES2: sdo_lvl = 1'b0;
            ppm_pkg::PPM_SDO_RXRDY: sdo_lvl = src.rx_ready;
            ppm_pkg::PPM_SDO_REFRDY: sdo_lvl = src.ref_clk_ready;
            ppm_pkg::PPM_SDO_LORDY: sdo_lvl = src.local_osc_ready;
            ppm_pkg::PPM_SDO_RXRDY2: sdo_lvl = src.rx_ready;
            ppm_pkg::PPM_SDO_RES7: sdo_lvl = 1'b0;
        endcase
        if (separate_serial_output) begin
            sdo_drv = src.spi_sdo_oe;
            sdo_lvl = src.spi_sdo;
        end
    end

    // aux pin source
    always_comb begin
        aux_drv = 1'b1;
        aux_lvl = 1'b0;
        unique case (aux_sel)
            ppm_pkg::PPM_AUX_HIZ: aux_drv = 1'b0;
            ppm_pkg::PPM_AUX_LOW: aux_lvl = 1'b0;
            ppm_pkg::PPM_AUX_RXM, ppm_pkg::PPM_AUX_RXM2: begin
                aux_drv = !src.rx_mode_n;
                aux_lvl = 1'b0;
            end
        endcase
    end

    // pin stages with polarity inversion
    ppm_pin_drive u_clk_drive (
        .drive(clk_drv),
        .level(clk_lvl),
        .invert(func_b_r[ppm_pkg::PPM_CLK_INV_BIT]),
        .pin(clk_pin_c)
    );
    ppm_pin_drive u_sdo_drive (
        .drive(sdo_drv),
        .level(sdo_lvl),
        .invert(func_b_r[ppm_pkg::PPM_SDO_INV_BIT] && !separate_serial_output),
        .pin(sdo_pin_c)
    );
    ppm_pin_drive u_aux_drive (
        .drive(aux_drv),
        .level(aux_lvl),
        .invert(ovr_c_r[ppm_pkg::PPM_AUX_INV_BIT]),
        .pin(aux_pin_c)
    );

    // data pin override and serial line steering
    always_comb begin
        pins_nxt.clock_pin = clk_pin_c;
        pins_nxt.serial_out_pin = sdo_pin_c;
        pins_nxt.aux_pin = aux_pin_c;
        pins_nxt.data_pin.oe = sep_rx && rx_on;
        pins_nxt.data_pin.o = sep_rx && rx_on && src.rx_data;
        pins_nxt.rx_data_to_serial_line = !sep_rx && !separate_serial_output;
        pins_nxt.rx_data_to_sdo = !sep_rx && separate_serial_output;
        pins_nxt.rx_clk_to_sclk = !sep_rx;
    end

    // pin outputs registered
    always_ff @(posedge clk) begin
        if (rst) begin
            pins <= '0;
        end else begin
            pins <= pins_nxt;
        end
    end

endmodule // ppm_top

// [testbench/ppm_top_monitor.sv]
// ppm_top_monitor: bus and pin assertions for the port pin mux
// assumes the master offers aw and w together; shadow registers track writes
`timescale 1ns/1ps
module ppm_top_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    // sources and pins
    input wire ppm_pkg::ppm_sources_t src,
    input wire ppm_pkg::ppm_pins_t pins
);
    // ****************************************
    // shadow registers
    // ****************************************
    logic [7:0] b_r, c_r, t_r, bp_r, cp_r, tp_r;
    ppm_pkg::ppm_sources_t sp_r;
    logic rq_r, rq2_r, wr_take, rxon;
    logic [2:0] csel, ssel, tsel;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_wstrb[0];
    // shadow follows writes, delayed copies line up with registered pins
    always_ff @(posedge clk) begin
        rq_r <= rst;
        rq2_r <= rq_r;
        sp_r <= src;
        bp_r <= b_r;
        cp_r <= c_r;
        tp_r <= t_r;
        if (rst) begin
            b_r <= ppm_pkg::PPM_RST_FUNC_B;
            c_r <= ppm_pkg::PPM_RST_OVR_C;
            t_r <= ppm_pkg::PPM_RST_TEST;
        end else if (wr_take) begin
            if (s_axi_awaddr == 32'(ppm_pkg::PPM_ADDR_FUNC_B)) b_r <= s_axi_wdata[7:0];
            if (s_axi_awaddr == 32'(ppm_pkg::PPM_ADDR_OVR_C)) c_r <= s_axi_wdata[7:0] & 8'hc7;
            if (s_axi_awaddr == 32'(ppm_pkg::PPM_ADDR_TEST)) t_r <= s_axi_wdata[7:0];
        end
    end
    // field aliases of the delayed shadow
    assign csel = bp_r[3:1];
    assign ssel = bp_r[7:5];
    assign tsel = tp_r[6:4];
    assign rxon = cp_r[6] && sp_r.rx_active;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst || rq_r || rq2_r);
    // ****************************************
    // assertions
    // ****************************************
    a_clk_hiz: assert property (csel == 3'h0 |-> !pins.clock_pin.oe)
        else $error("clock pin driven in hiz code");
    a_clk_gen: assert property (csel == 3'h3 |-> pins.clock_pin.oe
        && pins.clock_pin.o == (sp_r.gen_clk ^ bp_r[0])) else $error("clock pin gen wrong");
    a_clk_rx: assert property (csel == 3'h2 |-> pins.clock_pin.oe
        && pins.clock_pin.o == ((rxon && sp_r.rx_clk) ^ bp_r[0])) else $error("rx clock wrong");
    a_clk_test: assert property (csel[2:1] == 2'b11 |-> pins.clock_pin.o ==
        ((csel[0] ? sp_r.test_grp4[tsel] : sp_r.test_grp3[tsel]) ^ bp_r[0]))
        else $error("clock pin test signal wrong");
    a_sdo_sep: assert property (cp_r[7] |-> pins.serial_out_pin.oe == sp_r.spi_sdo_oe
        && (!sp_r.spi_sdo_oe || pins.serial_out_pin.o == sp_r.spi_sdo))
        else $error("serial out override wrong");
    a_sdo_rdy: assert property (!cp_r[7] && (ssel == 3'h3 || ssel == 3'h6)
        |-> pins.serial_out_pin.oe && pins.serial_out_pin.o == (sp_r.rx_ready ^ bp_r[4]))
        else $error("serial out ready flag wrong");
    a_data_rx: assert property (rxon |-> pins.data_pin.oe
        && pins.data_pin.o == sp_r.rx_data) else $error("data pin rx data wrong");
    a_aux_mode: assert property (cp_r[2] |-> pins.aux_pin.oe == !sp_r.rx_mode_n
        && (!pins.aux_pin.oe || pins.aux_pin.o == cp_r[0])) else $error("aux pin wrong");
    a_rst_pins: assert property (@(posedge clk) disable iff (rst) $fell(rst) |-> pins == '0)
        else $error("pins not cleared by reset");
    a_b_answer: assert property (wr_take |=> s_axi_bvalid) else $error("write response late");
    a_rx_steer: assert property (pins.rx_clk_to_sclk == !cp_r[6]
        && pins.rx_data_to_sdo == (!cp_r[6] && cp_r[7])
        && pins.rx_data_to_serial_line == (!cp_r[6] && !cp_r[7])) else $error("rx steering wrong");
    c_separate_serial_output: cover property (cp_r[7] && pins.serial_out_pin.oe);
    c_rx_clk: cover property (csel == 3'h2 && rxon);
    c_aux_rx: cover property (cp_r[2] && pins.aux_pin.oe);
endmodule // ppm_top_monitor

bind ppm_top ppm_top_monitor u_mon (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .src(src), .pins(pins));

// [testbench/ppm_host_model.sv]
// ppm_host_model: host controller sampling the four port pins
// assumes no pull resistors, so a released pin drifts from its last level
`timescale 1ns/1ps
module ppm_host_model (
    // clock
    input wire logic clk,
    // pins from the mux
    input wire ppm_pkg::ppm_pins_t pins,
    // sampled clock, serial out, aux and data levels
    output logic [3:0] lvl
);
    logic [3:0] oe, o;
    assign oe = {pins.clock_pin.oe, pins.serial_out_pin.oe, pins.aux_pin.oe, pins.data_pin.oe};
    assign o = {pins.clock_pin.o, pins.serial_out_pin.o, pins.aux_pin.o, pins.data_pin.o};
    initial lvl = 4'h0;
    // driven pin shows its value, floating pin the inverse of the last
    always @(posedge clk) begin
        lvl <= (oe & o) | (~oe & ~lvl);
    end
endmodule // ppm_host_model

// [testbench/ppm_top_tb.sv]
// ppm_top_tb: self-checking bench for the port pin mux
// assumes the status word mirrors the pins; sources come from an lfsr
`timescale 1ns/1ps
module ppm_top_tb;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [31:0] A_B = 32'(ppm_pkg::PPM_ADDR_FUNC_B);
    localparam logic [31:0] A_C = 32'(ppm_pkg::PPM_ADDR_OVR_C);
    localparam logic [31:0] A_T = 32'(ppm_pkg::PPM_ADDR_TEST);
    localparam logic [31:0] A_S = 32'(ppm_pkg::PPM_ADDR_STATUS);
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, lfsr = 32'haf736822;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] wstrb = 4'hf;
    logic [3:0] lvl;
    logic [1:0] bresp, rresp;
    ppm_pkg::ppm_sources_t src = '0;
    ppm_pkg::ppm_pins_t pins;
    int mismatches = 0, n_checks = 0;
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    always #20 clk = ~clk;
    ppm_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .src(src), .pins(pins));
    ppm_host_model host (.clk(clk), .pins(pins), .lvl(lvl));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // expected status {mask, value} from the three registers and sources
    function automatic logic [15:0] pin_exp(input logic [7:0] b, c, t,
        input ppm_pkg::ppm_sources_t s);
        logic [7:0] v, m;
        v = 8'h00;
        m = 8'hff;
        v[7] = b[3:1] != 3'h0;
        case (b[3:1])
            3'h2: v[6] = c[6] & s.rx_active & s.rx_clk;
            3'h3: v[6] = s.gen_clk;
            3'h4: v[6] = s.pll_fb_clk;
            3'h5: v[6] = s.poll_clk;
            3'h6: v[6] = s.test_grp3[t[6:4]];
            3'h7: v[6] = s.test_grp4[t[6:4]];
            default: v[6] = 1'b0;
        endcase
        v[6] = v[7] & (v[6] ^ b[0]);
        v[5] = b[7:5] != 3'h0;
        case (b[7:5])
            3'h3, 3'h6: v[4] = s.rx_ready;
            3'h4: v[4] = s.ref_clk_ready;
            3'h5: v[4] = s.local_osc_ready;
            3'h2, 3'h7: m[5:4] = 2'b00;
            default: v[4] = 1'b0;
        endcase
        v[4] = v[5] & (v[4] ^ b[4]);
        if (c[7]) begin
            v[5] = s.spi_sdo_oe;
            v[4] = s.spi_sdo_oe & s.spi_sdo;
            m[5:4] = 2'b11;
        end
        v[3] = (c[2:1] == 2'h1) | (c[2] & ~s.rx_mode_n);
        v[2] = v[3] & c[0];
        if (c[6] & s.rx_active) v[1:0] = {1'b1, s.rx_data};
        else m[1:0] = 2'b00;
        return {m, v};
    endfunction
    // ****************************************
    // bus tasks and comparisons
    // ****************************************
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin do @(posedge clk); while (!awready); awvalid <= 1'b0; end
            begin do @(posedge clk); while (!wready); wvalid <= 1'b0; end
        join
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [31:0] a, m, d, input logic [1:0] r);
        rq.push_back({r, m, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_st(input logic [7:0] b, c, t);
        logic [15:0] e;
        e = pin_exp(b, c, t, src);
        rd(A_S, {24'h0, e[15:8]}, {24'h0, e[7:0]}, 2'b00);
    endtask
    task automatic cmp_r(input logic [65:0] e, input logic [1:0] r, input logic [31:0] d);
        n_checks++;
        if (r !== e[65:64] || (d & e[63:32]) !== (e[31:0] & e[63:32])) begin
            mismatches++;
            $display("[ERR] read exp %h/%h seen %h/%h", e[65:64], e[31:0], r, d);
        end
    endtask
    task automatic cmp_b(input logic [1:0] e, input logic [1:0] r);
        n_checks++;
        if (r !== e) begin
            mismatches++;
            $display("[ERR] bresp exp %h seen %h", e, r);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // result watcher takes the oldest note per answer
    always @(posedge clk) begin
        if (bvalid && bready) cmp_b(bq.pop_front(), bresp);
        if (rvalid && rready) cmp_r(rq.pop_front(), rresp, rdata);
    end
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    // main sequence
    initial begin
        logic [7:0] b, c, t;
        logic [31:0] r;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(A_B, 32'hff, 32'h06, 2'b00);
        rd(A_C, 32'hff, 32'h00, 2'b00);
        rd_st(8'h06, 8'h00, 8'h00);
        wr(32'h0, 8'h5a, 2'b10);
        rd(32'h0, 32'hffffffff, 32'h0, 2'b10);
        wr(A_C, 8'hff, 2'b00);
        rd(A_C, 32'hff, 32'hc7, 2'b00);
        wstrb <= 4'h0;
        wr(A_B, 8'h00, 2'b00);
        wstrb <= 4'hf;
        rd(A_B, 32'hff, 32'h06, 2'b00);
        for (int i = 0; i < 64; i++) begin
            r = rnd();
            b = {i[5:3], r[4], i[2:0], r[0]};
            c = r[15:8] & 8'hc7;
            t = {1'b0, r[22:20], 4'h0};
            src <= ppm_pkg::ppm_sources_t'(28'(rnd()));
            wr(A_B, b, 2'b00);
            wr(A_C, c, 2'b00);
            wr(A_T, t, 2'b00);
            repeat (2) @(posedge clk);
            rd_st(b, c, t);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(A_C, 32'hff, 32'h00, 2'b00);
        rd_st(8'h06, 8'h00, 8'h00);
        finish_test();
    end
endmodule // ppm_top_tb
